/* hdl/nip_node_phy_regs.sv */
// node identification and phy register access register bank
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module nip_node_phy_regs
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [nip_pkg::NIP_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [nip_pkg::NIP_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic bus_reset_pulse,
   input wire logic phy_is_root,
   input wire logic phy_cable_power_ok,
   input wire logic node_number_valid,
   input wire logic [nip_pkg::NIP_NODE_W-1:0] node_number,
   output logic phy_read_request,
   output logic phy_write_request,
   output logic [nip_pkg::NIP_PHY_ADDR_W-1:0] phy_target_reg_index,
   output logic [nip_pkg::NIP_PHY_DATA_W-1:0] phy_write_value,
   input wire logic phy_request_sent,
   input wire logic phy_reg_transfer,
   input wire logic [nip_pkg::NIP_PHY_ADDR_W-1:0] phy_reg_transfer_addr,
   input wire logic [nip_pkg::NIP_PHY_DATA_W-1:0] phy_reg_transfer_data,
   output logic [15:0] node_identifier,
   output logic irq
);
   import nip_pkg::*;

   // ************************************************************************
   // axi4-lite write channel
   // ************************************************************************
   logic aw_held_r;
   logic w_held_r;
   logic [NIP_ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_fire;

   // both halves may arrive in either order; a write commits once both held
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
         w_held_r <= 1'b0;
      end
   end

   function automatic logic nip_mapped(input logic [NIP_ADDR_W-1:0] a);
      nip_mapped = (a == NIP_OFS_NODE_ID) || (a == NIP_OFS_PHY_CTRL) ||
                   (a == NIP_OFS_INT_STAT) || (a == NIP_OFS_INT_MASK);
   endfunction

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= NIP_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= nip_mapped(awaddr_r) ? NIP_RESP_OKAY : NIP_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic wr_node;
   logic wr_phy;
   logic wr_mask;
   assign wr_node = wr_fire && (awaddr_r == NIP_OFS_NODE_ID);
   assign wr_phy = wr_fire && (awaddr_r == NIP_OFS_PHY_CTRL);
   assign wr_mask = wr_fire && (awaddr_r == NIP_OFS_INT_MASK);

   // ************************************************************************
   // node identification state
   // ************************************************************************
   logic node_id_valid_r;
   logic root_r;
   logic cable_power_ok_r;
   logic [NIP_BUS_W-1:0] bus_index_r;
   logic [NIP_NODE_W-1:0] physical_node_index_r;
   logic [1:0] pin_meta_r;
   logic [1:0] pin_sync_r;

   // root and cable power pins pass through two synchronizer flops first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end
      else
      begin
         pin_meta_r <= {phy_is_root, phy_cable_power_ok};
         pin_sync_r <= pin_meta_r;
      end
   end

   // a new node number in the same cycle as a reset is taken as the newer event
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         node_id_valid_r <= 1'b0;
         physical_node_index_r <= '0;
      end
      else if (node_number_valid)
      begin
         node_id_valid_r <= 1'b1;
         physical_node_index_r <= node_number;
      end
      else if (bus_reset_pulse)
      begin
         node_id_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         root_r <= 1'b0;
      end
      else if (bus_reset_pulse)
      begin
         root_r <= pin_sync_r[1];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cable_power_ok_r <= 1'b0;
      end
      else
      begin
         cable_power_ok_r <= pin_sync_r[0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bus_index_r <= NIP_BUS_RST;
      end
      else if (wr_node)
      begin
         // field spans lanes 0 and 1
         if (wstrb_r[0])
         begin
            bus_index_r[1:0] <= wdata_r[7:6];
         end
         if (wstrb_r[1])
         begin
            bus_index_r[9:2] <= wdata_r[15:8];
         end
      end
   end

   assign node_identifier = {bus_index_r, physical_node_index_r};

   // ************************************************************************
   // phy_register_access_control state
   // ************************************************************************
   logic phy_read_complete_r;
   logic [NIP_PHY_ADDR_W-1:0] phy_read_reg_index_r;
   logic [NIP_PHY_DATA_W-1:0] phy_read_value_r;
   logic rd_req_r;
   logic wr_req_r;
   logic [NIP_PHY_ADDR_W-1:0] taddr_r;
   logic [NIP_PHY_DATA_W-1:0] wval_r;
   logic req_set;

   assign req_set = wr_phy && wstrb_r[1] &&
                    (wdata_r[NIP_PC_RDREQ] || wdata_r[NIP_PC_WRREQ]);

   // arrival wins over a simultaneous request write so no completion is lost
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phy_read_complete_r <= 1'b0;
         phy_read_reg_index_r <= '0;
         phy_read_value_r <= '0;
      end
      else if (phy_reg_transfer)
      begin
         phy_read_complete_r <= 1'b1;
         phy_read_reg_index_r <= phy_reg_transfer_addr;
         phy_read_value_r <= phy_reg_transfer_data;
      end
      else if (req_set)
      begin
         phy_read_complete_r <= 1'b0;
      end
   end

   // a write with either request bit set loads both request bits; hardware clears once sent
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_req_r <= 1'b0;
         wr_req_r <= 1'b0;
      end
      else if (req_set)
      begin
         rd_req_r <= wdata_r[NIP_PC_RDREQ];
         wr_req_r <= wdata_r[NIP_PC_WRREQ];
      end
      else if (phy_request_sent)
      begin
         rd_req_r <= 1'b0;
         wr_req_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         taddr_r <= '0;
         wval_r <= '0;
      end
      else if (wr_phy)
      begin
         if (wstrb_r[1])
         begin
            taddr_r <= wdata_r[NIP_PC_TADDR_LSB +: NIP_PHY_ADDR_W];
         end
         if (wstrb_r[0])
         begin
            wval_r <= wdata_r[NIP_PHY_DATA_W-1:0];
         end
      end
   end

   assign phy_read_request = rd_req_r;
   assign phy_write_request = wr_req_r;
   assign phy_target_reg_index = taddr_r;
   assign phy_write_value = wval_r;

   // ************************************************************************
   // interrupts
   // ************************************************************************
   logic [NIP_IRQ_W-1:0] int_stat_r;
   logic [NIP_IRQ_W-1:0] int_mask_r;
   logic [NIP_IRQ_W-1:0] int_evt;
   logic rd_stat;

   assign int_evt[NIP_IRQ_DONE] = phy_reg_transfer;
   assign int_evt[NIP_IRQ_RESET] = bus_reset_pulse;
   assign int_evt[NIP_IRQ_NODE] = node_number_valid;

   // set wins over the read-clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         int_stat_r <= '0;
      end
      else if (rd_stat)
      begin
         int_stat_r <= int_evt;
      end
      else
      begin
         int_stat_r <= int_stat_r | int_evt;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         int_mask_r <= '0;
      end
      else if (wr_mask && wstrb_r[0])
      begin
         int_mask_r <= wdata_r[NIP_IRQ_W-1:0];
      end
   end

   assign irq = |(int_stat_r & int_mask_r);

   // ************************************************************************
   // axi4-lite read channel
   // ************************************************************************
   logic [31:0] rd_word;
   logic rd_ok;

   assign s_axi_arready = !s_axi_rvalid;
   assign rd_stat = s_axi_arvalid && s_axi_arready && (s_axi_araddr == NIP_OFS_INT_STAT);

   always_comb
   begin
      rd_word = '0;
      rd_ok = 1'b1;
      if (s_axi_araddr == NIP_OFS_NODE_ID)
      begin
         rd_word[NIP_NID_VALID] = node_id_valid_r;
         rd_word[NIP_NID_ROOT] = root_r;
         rd_word[NIP_NID_CPS] = cable_power_ok_r;
         rd_word[NIP_BUS_LSB +: NIP_BUS_W] = bus_index_r;
         rd_word[NIP_NODE_W-1:0] = physical_node_index_r;
      end
      else if (s_axi_araddr == NIP_OFS_PHY_CTRL)
      begin
         rd_word[NIP_PC_DONE] = phy_read_complete_r;
         rd_word[NIP_PC_RADDR_LSB +: NIP_PHY_ADDR_W] = phy_read_reg_index_r;
         rd_word[NIP_PC_RDATA_LSB +: NIP_PHY_DATA_W] = phy_read_value_r;
         rd_word[NIP_PC_RDREQ] = rd_req_r;
         rd_word[NIP_PC_WRREQ] = wr_req_r;
         rd_word[NIP_PC_TADDR_LSB +: NIP_PHY_ADDR_W] = taddr_r;
         rd_word[NIP_PHY_DATA_W-1:0] = wval_r;
      end
      else if (s_axi_araddr == NIP_OFS_INT_STAT)
      begin
         rd_word[NIP_IRQ_W-1:0] = int_stat_r;
      end
      else if (s_axi_araddr == NIP_OFS_INT_MASK)
      begin
         rd_word[NIP_IRQ_W-1:0] = int_mask_r;
      end
      else
      begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= NIP_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? NIP_RESP_OKAY : NIP_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* hdl/nip_pkg.sv */
// constants for the node identification and phy register access block
// ****************************************************************************
// Functional notes
// - node_id_valid clears on bus reset, sets when phy delivers node number.
// - root flag bit 30 set during bus reset when phy reports root.
// - node id reserved bits 29-28 and 26-16 read as zero.
// - cable_power_ok bit 27 set while phy reports cable power good.
// - bus_index bits 15-6 read/write, defaults all ones.
// - physical_node_index bits 5-0 loaded from phy after self id.
// - phy_read_complete clears when software sets read or write request.
// - phy_read_complete sets when a register transfer arrives from phy.
// - phy_read_reg_index holds address of latest received register transfer.
// - phy_read_value holds data of latest received register transfer.
// - read request bit 15 set by software, cleared once sent.
// - write request bit 14 set by software, cleared once sent.
// - phy_target_reg_index bits 11-8 read/write, default zero.
// - phy_write_value bits 7-0 read/write, default zero, unused for reads.
// - phy_register_access_control reserved bits 30-28 and 13-12 read as zero.
// - bus_index and physical_node_index form 16-bit node identifier.
// ****************************************************************************
package nip_pkg;
   localparam logic [7:0] NIP_OFS_NODE_ID = 8'he8;
   localparam logic [7:0] NIP_OFS_PHY_CTRL = 8'hec;
   localparam logic [7:0] NIP_OFS_INT_STAT = 8'hf8;
   localparam logic [7:0] NIP_OFS_INT_MASK = 8'hfc;
   localparam int NIP_ADDR_W = 8;
   // node identification fields
   localparam int NIP_NID_VALID = 31;
   localparam int NIP_NID_ROOT = 30;
   localparam int NIP_NID_CPS = 27;
   localparam int NIP_BUS_LSB = 6;
   localparam int NIP_BUS_W = 10;
   localparam int NIP_NODE_W = 6;
   localparam logic [9:0] NIP_BUS_RST = 10'h3ff;
   // phy_register_access_control fields
   localparam int NIP_PC_DONE = 31;
   localparam int NIP_PC_RADDR_LSB = 24;
   localparam int NIP_PC_RDATA_LSB = 16;
   localparam int NIP_PC_RDREQ = 15;
   localparam int NIP_PC_WRREQ = 14;
   localparam int NIP_PC_TADDR_LSB = 8;
   localparam int NIP_PHY_ADDR_W = 4;
   localparam int NIP_PHY_DATA_W = 8;
   // interrupt status bits
   localparam int NIP_IRQ_W = 3;
   localparam int NIP_IRQ_DONE = 0;
   localparam int NIP_IRQ_RESET = 1;
   localparam int NIP_IRQ_NODE = 2;
   localparam logic [1:0] NIP_RESP_OKAY = 2'b00;
   localparam logic [1:0] NIP_RESP_SLVERR = 2'b10;
endpackage

/* tb/nip_regs_checker.sv */
// port assertions for the node id and phy access register bank
`timescale 1ns/1ps
`default_nettype none
module nip_regs_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [nip_pkg::NIP_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic node_number_valid,
   input wire logic [nip_pkg::NIP_NODE_W-1:0] node_number,
   input wire logic phy_read_request,
   input wire logic phy_write_request,
   input wire logic [nip_pkg::NIP_PHY_ADDR_W-1:0] phy_target_reg_index,
   input wire logic [nip_pkg::NIP_PHY_DATA_W-1:0] phy_write_value,
   input wire logic phy_request_sent,
   input wire logic phy_reg_transfer,
   input wire logic [15:0] node_identifier
);
   import nip_pkg::*;
   logic [NIP_ADDR_W-1:0] ar_r;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // *****
   // address of the read now answering
   // *****
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ar_r <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready)
         ar_r <= s_axi_araddr;
   end
   // a software write in the same cycle may set a request again
   property p_req_clear;
      phy_request_sent |=> !(phy_read_request || phy_write_request) || $rose(s_axi_bvalid);
   endproperty
   a_req_clear: assert property (p_req_clear) else $error("request kept");
   property p_req_rise;
      $rose(phy_read_request) || $rose(phy_write_request) |-> $rose(s_axi_bvalid);
   endproperty
   a_req_rise: assert property (p_req_rise) else $error("request rose alone");
   property p_node_load;
      node_number_valid |=> node_identifier[5:0] == $past(node_number);
   endproperty
   a_node_load: assert property (p_node_load) else $error("node index not loaded");
   property p_node_hold;
      !node_number_valid |=> $stable(node_identifier[5:0]);
   endproperty
   a_node_hold: assert property (p_node_hold) else $error("node index moved");
   property p_bus_hold;
      $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable(node_identifier[15:6]);
   endproperty
   a_bus_hold: assert property (p_bus_hold) else $error("bus index moved");
   property p_cfg_hold;
      $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable({phy_target_reg_index, phy_write_value});
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("target or value moved");
   property p_nid_rsvd;
      s_axi_rvalid && ar_r == NIP_OFS_NODE_ID |->
         {s_axi_rdata[29:28], s_axi_rdata[26:16]} == 13'h0;
   endproperty
   a_nid_rsvd: assert property (p_nid_rsvd) else $error("node id reserved set");
   property p_pc_rsvd;
      s_axi_rvalid && ar_r == NIP_OFS_PHY_CTRL |->
         {s_axi_rdata[30:28], s_axi_rdata[13:12]} == 5'h0;
   endproperty
   a_pc_rsvd: assert property (p_pc_rsvd) else $error("phy ctrl reserved set");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read not answered");
   c_sent: cover property (phy_request_sent);
   c_xfer: cover property (phy_reg_transfer);
   c_node: cover property (node_number_valid);
endmodule
bind nip_node_phy_regs nip_regs_checker u_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .node_number_valid, .node_number,
   .phy_read_request, .phy_write_request, .phy_target_reg_index, .phy_write_value,
   .phy_request_sent, .phy_reg_transfer, .node_identifier);
`default_nettype wire

/* tb/nip_phy_model.sv */
// behavioural attached phy answering register requests
`timescale 1ns/1ps
`default_nettype none
module nip_phy_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slow,
   input wire logic rd_req,
   input wire logic wr_req,
   input wire logic [3:0] idx,
   input wire logic [7:0] wval,
   output logic sent,
   output logic xfer,
   output logic [3:0] xaddr,
   output logic [7:0] xdata
);
   logic [7:0] mem_r [16];
   logic [2:0] cnt_r;
   logic rpend_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < 16; i++)
            mem_r[i] <= 8'h00;
         cnt_r <= 3'h0;
         rpend_r <= 1'b0;
         sent <= 1'b0;
         xfer <= 1'b0;
         xaddr <= 4'h0;
         xdata <= 8'h00;
      end
      else
      begin
         sent <= 1'b0;
         xfer <= 1'b0;
         // idle lines wobble so a stale value cannot pass
         xaddr <= ~xaddr;
         xdata <= ~xdata;
         if (cnt_r == 3'h0 && (rd_req || wr_req) && !sent)
            cnt_r <= slow ? 3'h6 : 3'h1;
         else if (cnt_r == 3'h1)
         begin
            sent <= 1'b1;
            cnt_r <= 3'h0;
            rpend_r <= rd_req;
            if (wr_req)
               mem_r[idx] <= wval;
         end
         else if (cnt_r != 3'h0)
            cnt_r <= cnt_r - 3'h1;
         if (rpend_r)
         begin
            xfer <= 1'b1;
            xaddr <= idx;
            xdata <= mem_r[idx];
            rpend_r <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/nip_node_phy_regs_tb.sv */
// self-checking bench for the node id and phy access register bank
`timescale 1ns/1ps
`default_nettype none
module nip_node_phy_regs_tb;
   import nip_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, phy_target_reg_index, phy_reg_transfer_addr;
   logic bus_reset_pulse = 1'b0, phy_is_root = 1'b0, phy_cable_power_ok = 1'b0;
   logic node_number_valid = 1'b0;
   logic [5:0] node_number = 6'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic phy_read_request, phy_write_request, phy_request_sent, phy_reg_transfer;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] phy_write_value, phy_reg_transfer_data;
   logic [15:0] node_identifier;
   int fails = 0, cmp_count = 0;
   integer seed = 32'h5141;
   logic [33:0] qr[$], qb[$];
   nip_node_phy_regs uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .bus_reset_pulse, .phy_is_root, .phy_cable_power_ok,
      .node_number_valid, .node_number, .phy_read_request, .phy_write_request,
      .phy_target_reg_index, .phy_write_value, .phy_request_sent, .phy_reg_transfer,
      .phy_reg_transfer_addr, .phy_reg_transfer_data, .node_identifier, .irq);
   nip_phy_model phy (.aclk, .aresetn, .slow, .rd_req(phy_read_request),
      .wr_req(phy_write_request), .idx(phy_target_reg_index), .wval(phy_write_value),
      .sent(phy_request_sent), .xfer(phy_reg_transfer), .xaddr(phy_reg_transfer_addr),
      .xdata(phy_reg_transfer_data));
   always #20 aclk = ~aclk;
   // *****
   // checking and bus tasks
   // *****
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 50)
      begin
         fails++;
         $display("[FAIL] wait expected done seen timeout");
         end_sim();
      end
   endtask
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         chk("read", {s_axi_rresp, s_axi_rdata}, qr.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         chk("bresp", {s_axi_bresp, 32'h0}, qb.pop_front());
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      qb.push_back({er, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!(s_axi_bvalid && s_axi_bready) && n < 50);
      s_axi_bready <= 1'b0;
      tmo(n);
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      qr.push_back({er, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      // hold the request until taken, then wait for the answer itself
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!(s_axi_rvalid && s_axi_rready) && n < 50);
      tmo(n);
      @(posedge aclk);
   endtask
   task automatic pulse(input logic rst);
      if (rst)
         bus_reset_pulse <= 1'b1;
      else
         node_number_valid <= 1'b1;
      @(posedge aclk);
      bus_reset_pulse <= 1'b0;
      node_number_valid <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wait_phy(input logic want_irq);
      int n;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while ((phy_read_request || phy_write_request || (want_irq && !irq)) && n < 50);
      tmo(n);
   endtask
   // *****
   // main sequence
   // *****
   initial
   begin
      logic [31:0] d;
      logic [9:0] b;
      logic [5:0] nn;
      logic [3:0] t, t2;
      logic [7:0] v, v2;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("node_identifier", {18'h0, node_identifier}, {18'h0, 16'hffc0});
      rd(NIP_OFS_NODE_ID, 32'h0000ffc0, NIP_RESP_OKAY);
      rd(NIP_OFS_PHY_CTRL, 32'h0, NIP_RESP_OKAY);
      repeat (4)
      begin
         d = $random(seed);
         b = d[15:6];
         wr(NIP_OFS_NODE_ID, d, NIP_RESP_OKAY);
         rd(NIP_OFS_NODE_ID, {16'h0, b, 6'h0}, NIP_RESP_OKAY);
         chk("node_identifier", {18'h0, node_identifier}, {18'h0, b, 6'h0});
         d = d & 32'hffff3fff;
         wr(NIP_OFS_PHY_CTRL, d, NIP_RESP_OKAY);
         rd(NIP_OFS_PHY_CTRL, {20'h0, d[11:0]}, NIP_RESP_OKAY);
      end
      phy_cable_power_ok <= 1'b1;
      phy_is_root <= 1'b1;
      nn = 6'($random(seed));
      node_number <= nn;
      repeat (4) @(posedge aclk);
      rd(NIP_OFS_NODE_ID, {8'h08, 8'h00, b, 6'h0}, NIP_RESP_OKAY);
      pulse(1'b0);
      rd(NIP_OFS_NODE_ID, {8'h88, 8'h00, b, nn}, NIP_RESP_OKAY);
      pulse(1'b1);
      rd(NIP_OFS_NODE_ID, {8'h48, 8'h00, b, nn}, NIP_RESP_OKAY);
      node_number <= 6'h3f;
      pulse(1'b0);
      rd(NIP_OFS_NODE_ID, {8'hc8, 8'h00, b, 6'h3f}, NIP_RESP_OKAY);
      chk("irq", {33'h0, irq}, 34'h0);
      rd(NIP_OFS_INT_STAT, 32'h6, NIP_RESP_OKAY);
      rd(NIP_OFS_INT_STAT, 32'h0, NIP_RESP_OKAY);
      wr(NIP_OFS_INT_MASK, 32'h1, NIP_RESP_OKAY);
      rd(NIP_OFS_INT_MASK, 32'h1, NIP_RESP_OKAY);
      t = 4'($random(seed));
      v = 8'($random(seed));
      v2 = 8'($random(seed));
      t2 = 4'($random(seed));
      slow <= 1'b1;
      wr(NIP_OFS_PHY_CTRL, {16'h0, 4'h4, t, v}, NIP_RESP_OKAY);
      chk("phy_out", {20'h0, phy_read_request, phy_write_request, phy_target_reg_index,
         phy_write_value}, {20'h0, 2'b01, t, v});
      wait_phy(1'b0);
      slow <= 1'b0;
      wr(NIP_OFS_PHY_CTRL, {16'h0, 4'h8, t, v2}, NIP_RESP_OKAY);
      wait_phy(1'b1);
      chk("irq", {33'h0, irq}, 34'h1);
      rd(NIP_OFS_PHY_CTRL, {4'h8, t, v, 4'h0, t, v2}, NIP_RESP_OKAY);
      rd(NIP_OFS_INT_STAT, 32'h1, NIP_RESP_OKAY);
      chk("irq", {33'h0, irq}, 34'h0);
      wr(NIP_OFS_PHY_CTRL, {16'h0, 4'h4, t2, v2}, NIP_RESP_OKAY);
      wait_phy(1'b0);
      rd(NIP_OFS_PHY_CTRL, {4'h0, t, v, 4'h0, t2, v2}, NIP_RESP_OKAY);
      wr(8'h40, 32'hffffffff, NIP_RESP_SLVERR);
      rd(8'h40, 32'h0, NIP_RESP_SLVERR);
      repeat (2) @(posedge aclk);
      chk("pending", 34'(qr.size() + qb.size()), 34'h0);
      end_sim();
   end
endmodule
`default_nettype wire
